// ---- logic/swbd_pkg.sv ----
// constants for the single-wire background debug controller
//
// Functional notes
// - power-on reset with debug pin low enters debug halt mode
// - force_background_bit write plus pin low after it resets into debug halt mode
// - pin or error resets ignore the debug pin, start the user program
// - halt-only commands accepted only while the core sits in debug halt mode
// - halt-only group: processor register read/write, single step, resume
// - non-intrusive commands run at any time, no core halt needed
// - non-intrusive commands reach memory and the controller status/control
// - halt command wakes core from stop or wait into debug halt mode
// - operating watchdog held off while in debug halt mode
// - controller enabled keeps oscillator running in stop
// - one hardware address breakpoint comparator inside the controller
// - controller registers reached only by serial commands, not memory mapped
// - bit starts on pod falling edge, sixteen cycles, msb first
// - 512 cycles between falling edges aborts command, nothing changed
// - pod-to-target bit sampled ten cycles after perceived start
// - zero bit driven low thirteen cycles then brief high speedup
`default_nettype none
package swbd_pkg;
   // ==========================================
   // serial timing, in debug clock cycles
   localparam int BIT_CYC       = 16;
   localparam int SAMPLE_CYC    = 10;
   localparam int ZERO_LOW_CYC  = 13;
   localparam int ONE_SPEED_CYC = 7;
   localparam int TIMEOUT_CYC   = 512;
   localparam int BOOT_WAIT     = 2;
   // ==========================================
   // command codes
   localparam logic [7:0] CMD_HALT     = 8'h90;
   localparam logic [7:0] CMD_GO       = 8'h08;
   localparam logic [7:0] CMD_STEP     = 8'h10;
   localparam logic [7:0] CMD_RD_STAT  = 8'he4;
   localparam logic [7:0] CMD_WR_CTRL  = 8'hc4;
   localparam logic [7:0] CMD_RD_BYTE  = 8'he0;
   localparam logic [7:0] CMD_WR_BYTE  = 8'hc0;
   localparam logic [7:0] CMD_RD_BKPT  = 8'he2;
   localparam logic [7:0] CMD_WR_BKPT  = 8'hc2;
   localparam logic [7:0] CMD_WR_FORCE = 8'h18;
   localparam logic [4:0] CMD_WREG_HI  = 5'h08;
   localparam logic [4:0] CMD_RREG_HI  = 5'h0c;
   // ==========================================
   // control register fields and reset values
   localparam int         CTRL_EN_POS   = 7;
   localparam int         CTRL_BKPT_POS = 6;
   localparam int         FORCE_POS     = 0;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [15:0] BKPT_RESET   = 16'h0000;
   localparam logic [4:0] LEN_NONE      = 5'h00;
   localparam logic [4:0] LEN_BYTE      = 5'h08;
   localparam logic [4:0] LEN_WORD      = 5'h10;
endpackage
`default_nettype wire

// ---- logic/swbd_ctrl.sv ----
// single-wire background debug controller, device side
`default_nettype none
`timescale 1ns/100ps
module swbd_ctrl
   import swbd_pkg::*;
#(
   parameter int TIMEOUT = TIMEOUT_CYC
)
(
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   input  wire logic        CE,
   input  wire logic        DEBUG_PIN_IN,
   input  wire logic        RST_CAUSE_POR,
   input  wire logic        RST_CAUSE_FORCED,
   input  wire logic        CORE_HALTED,
   input  wire logic        CORE_FETCH,
   input  wire logic [15:0] CORE_ADDR,
   input  wire logic [15:0] REG_RDATA,
   input  wire logic [7:0]  MEM_RDATA,
   input  wire logic        MEM_ACK,
   output var  logic        DEBUG_PIN_OUT,
   output var  logic        DEBUG_PIN_OE,
   output var  logic        HALT_REQ,
   output var  logic        GO,
   output var  logic        STEP,
   output var  logic        REG_WR,
   output var  logic [2:0]  REG_SEL,
   output var  logic [15:0] REG_WDATA,
   output var  logic        MEM_RD,
   output var  logic        MEM_WR,
   output var  logic [15:0] MEM_ADDR,
   output var  logic [7:0]  MEM_WDATA,
   output var  logic        FORCE_RST,
   output var  logic        WDOG_HOLD,
   output var  logic        OSC_KEEP,
   output var  logic        BKPT_HIT,
   output var  logic        BG_MODE
);
   // ==========================================
   // elaboration check
   localparam int GW = $clog2(TIMEOUT + 1);
   if (TIMEOUT <= BIT_CYC || TIMEOUT > 65535)
      $error("swbd_ctrl: TIMEOUT out of range");

   typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_WR, ST_WAIT, ST_RD} swbd_st_t;

   // ==========================================
   // command decode
   function automatic logic f_halt_only(input logic [7:0] c);
      f_halt_only = c == CMD_GO || c == CMD_STEP || c[7:3] == CMD_WREG_HI || c[7:3] == CMD_RREG_HI;
   endfunction

   function automatic logic [4:0] f_wlen(input logic [7:0] c);
      if (c == CMD_WR_CTRL || c == CMD_WR_BYTE || c == CMD_WR_FORCE)
         f_wlen = LEN_BYTE;
      else if (c == CMD_WR_BKPT || c[7:3] == CMD_WREG_HI)
         f_wlen = LEN_WORD;
      else
         f_wlen = LEN_NONE;
   endfunction

   function automatic logic [4:0] f_rlen(input logic [7:0] c);
      if (c == CMD_RD_STAT || c == CMD_RD_BYTE)
         f_rlen = LEN_BYTE;
      else if (c == CMD_RD_BKPT || c[7:3] == CMD_RREG_HI)
         f_rlen = LEN_WORD;
      else
         f_rlen = LEN_NONE;
   endfunction

   // ==========================================
   // state
   swbd_st_t    st;
   logic        pin_s1;
   logic        pin_s2;
   logic        pin_d;
   logic        bit_on;
   logic        tx_bit;
   logic [3:0]  cyc;
   logic [GW-1:0] gap;
   logic [4:0]  cnt;
   logic [15:0] rx_sh;
   logic [15:0] tx_sh;
   logic [7:0]  cmd;
   logic [7:0]  ctrl;
   logic [15:0] bkpt;
   logic [1:0]  boot_cnt;
   logic        boot_done;

   // ==========================================
   // bit timing decode
   // no bit starts before the boot check; a pod holding the pin low through reset is not a bit
   wire         fall     = pin_d & ~pin_s2 & boot_done;
   wire         rx_st    = st == ST_CMD || st == ST_ADDR || st == ST_WR;
   wire         sample   = bit_on && cyc == 4'(SAMPLE_CYC) && rx_st;
   wire         bit_end  = bit_on && cyc == 4'(BIT_CYC - 1);
   wire         active   = st != ST_CMD || cnt != 5'h00 || bit_on;
   wire         timeout  = active && !fall && gap == GW'(TIMEOUT - 1);
   wire [15:0]  next_rx  = {rx_sh[14:0], pin_s2};
   wire [7:0]   cur_cmd  = st == ST_CMD ? next_rx[7:0] : cmd;
   wire [4:0]   wlen     = f_wlen(cur_cmd);
   wire [4:0]   rlen     = f_rlen(cmd);
   wire [4:0]   ph_len   = st == ST_CMD ? LEN_BYTE : st == ST_ADDR ? LEN_WORD : wlen;
   wire         last_rx  = sample && !timeout && cnt == ph_len - 5'h01;
   wire         refused  = st == ST_CMD && f_halt_only(cur_cmd) && !BG_MODE;
   wire         to_addr  = st == ST_CMD && cur_cmd == CMD_RD_BYTE || st == ST_CMD && cur_cmd == CMD_WR_BYTE;
   wire         to_wr    = st != ST_WR && wlen != LEN_NONE;
   wire         exec     = last_rx && !refused && !to_addr && !to_wr;
   wire         tx_zero  = !tx_sh[15];
   wire         next_oe  = st == ST_RD && tx_bit && bit_on &&
                           (tx_zero ? cyc <= 4'(ZERO_LOW_CYC) : cyc == 4'(ONE_SPEED_CYC));
   wire         next_out = tx_zero ? cyc == 4'(ZERO_LOW_CYC) : 1'b1;
   wire         boot_eval = !boot_done && boot_cnt == 2'(BOOT_WAIT);
   wire         boot_bg  = boot_eval && !pin_s2 && (RST_CAUSE_POR || RST_CAUSE_FORCED);
   wire         next_hit = ctrl[CTRL_BKPT_POS] && CORE_FETCH && CORE_ADDR == bkpt && !CORE_HALTED;
   wire [7:0]   status   = {ctrl[CTRL_EN_POS], ctrl[CTRL_BKPT_POS], BG_MODE, 5'h00};

   // ==========================================
   // pin synchroniser; sync flops idle high like the pulled-up line
   always_ff @(posedge MCLK)
      if (!RST_N)
      begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
         pin_d  <= 1'b1;
      end
      else if (CE)
      begin
         pin_s1 <= DEBUG_PIN_IN;
         pin_s2 <= pin_s1;
         pin_d  <= pin_s2;
      end

   // ==========================================
   // bit engine and inter-edge timeout
   always_ff @(posedge MCLK)
      if (!RST_N)
      begin
         bit_on <= 1'b0;
         tx_bit <= 1'b0;
         cyc    <= 4'h0;
         gap    <= '0;
      end
      else if (CE)
      begin
         if (fall)
         begin
            bit_on <= 1'b1;
            // only bits begun in the read phase send; the tail of the last command bit must not
            tx_bit <= st == ST_RD;
            cyc    <= 4'h0;
         end
         else if (bit_on)
         begin
            cyc    <= cyc + 4'h1;
            bit_on <= !bit_end;
         end
         if (fall || timeout || !active)
            gap <= '0;
         else
            gap <= gap + GW'(1);
      end

   // ==========================================
   // pin drive, registered so the pad sees a clean edge
   always_ff @(posedge MCLK)
      if (!RST_N)
      begin
         DEBUG_PIN_OE  <= 1'b0;
         DEBUG_PIN_OUT <= 1'b1;
      end
      else if (CE)
      begin
         DEBUG_PIN_OE  <= next_oe;
         DEBUG_PIN_OUT <= next_out;
      end

   // ==========================================
   // command sequencer; actions only at the last bit so an abort leaves nothing behind
   always_ff @(posedge MCLK)
      if (!RST_N)
      begin
         st     <= ST_CMD;
         cnt    <= 5'h00;
         rx_sh  <= 16'h0000;
         tx_sh  <= 16'h0000;
         cmd    <= 8'h00;
         REG_SEL <= 3'h0;
         MEM_ADDR <= 16'h0000;
      end
      else if (CE)
      begin
         if (timeout)
         begin
            st  <= ST_CMD;
            cnt <= 5'h00;
         end
         else
            unique case (st)
               ST_CMD, ST_ADDR, ST_WR:
                  if (sample)
                  begin
                     rx_sh <= next_rx;
                     cnt   <= last_rx ? 5'h00 : cnt + 5'h01;
                     if (last_rx && st == ST_CMD)
                     begin
                        cmd     <= next_rx[7:0];
                        REG_SEL <= next_rx[2:0];
                     end
                     if (last_rx && st == ST_ADDR)
                        MEM_ADDR <= next_rx;
                     if (last_rx)
                     begin
                        if (refused)
                           st <= ST_CMD;
                        else if (to_addr)
                           st <= ST_ADDR;
                        else if (to_wr)
                           st <= ST_WR;
                        else if (cur_cmd == CMD_RD_BYTE || cur_cmd[7:3] == CMD_RREG_HI)
                           st <= ST_WAIT;
                        else if (f_rlen(cur_cmd) != LEN_NONE)
                           st <= ST_RD;
                        else
                           st <= ST_CMD;
                     end
                     if (exec && cur_cmd == CMD_RD_STAT)
                        tx_sh <= {status, 8'h00};
                     else if (exec && cur_cmd == CMD_RD_BKPT)
                        tx_sh <= bkpt;
                  end
               ST_WAIT:
                  // register data taken a cycle late so the core already sees the new REG_SEL
                  if (cmd[7:3] == CMD_RREG_HI)
                  begin
                     tx_sh <= REG_RDATA;
                     st    <= ST_RD;
                  end
                  else if (MEM_ACK)
                  begin
                     tx_sh <= {MEM_RDATA, 8'h00};
                     st    <= ST_RD;
                  end
               ST_RD:
                  if (bit_end && tx_bit)
                  begin
                     tx_sh <= {tx_sh[14:0], 1'b0};
                     cnt   <= cnt == rlen - 5'h01 ? 5'h00 : cnt + 5'h01;
                     if (cnt == rlen - 5'h01)
                        st <= ST_CMD;
                  end
            endcase
      end

   // ==========================================
   // command actions; controller registers live only here, off the memory map
   always_ff @(posedge MCLK)
      if (!RST_N)
      begin
         GO        <= 1'b0;
         STEP      <= 1'b0;
         REG_WR    <= 1'b0;
         REG_WDATA <= 16'h0000;
         MEM_RD    <= 1'b0;
         MEM_WR    <= 1'b0;
         MEM_WDATA <= 8'h00;
         FORCE_RST <= 1'b0;
         ctrl      <= CTRL_RESET;
         bkpt      <= BKPT_RESET;
      end
      else if (CE)
      begin
         GO        <= exec && cur_cmd == CMD_GO;
         STEP      <= exec && cur_cmd == CMD_STEP;
         REG_WR    <= exec && cur_cmd[7:3] == CMD_WREG_HI;
         MEM_RD    <= exec && cur_cmd == CMD_RD_BYTE;
         MEM_WR    <= exec && cur_cmd == CMD_WR_BYTE;
         FORCE_RST <= exec && cur_cmd == CMD_WR_FORCE && next_rx[FORCE_POS];
         if (exec && cur_cmd[7:3] == CMD_WREG_HI)
            REG_WDATA <= next_rx;
         if (exec && cur_cmd == CMD_WR_BYTE)
            MEM_WDATA <= next_rx[7:0];
         if (exec && cur_cmd == CMD_WR_CTRL)
            ctrl <= next_rx[7:0];
         if (exec && cur_cmd == CMD_WR_BKPT)
            bkpt <= next_rx;
      end

   // ==========================================
   // mode, boot choice, breakpoint and system controls
   // the pin is read only after the synchroniser has filled from the live pad
   always_ff @(posedge MCLK)
      if (!RST_N)
      begin
         boot_cnt  <= 2'h0;
         boot_done <= 1'b0;
         HALT_REQ  <= 1'b0;
         BKPT_HIT  <= 1'b0;
         BG_MODE   <= 1'b0;
         WDOG_HOLD <= 1'b0;
         OSC_KEEP  <= 1'b0;
      end
      else if (CE)
      begin
         if (!boot_done)
            boot_cnt <= boot_cnt + 2'h1;
         if (boot_eval)
            boot_done <= 1'b1;
         // set wins over the clear by the halted core
         if (boot_bg || next_hit || exec && cur_cmd == CMD_HALT)
            HALT_REQ <= 1'b1;
         else if (CORE_HALTED)
            HALT_REQ <= 1'b0;
         BKPT_HIT  <= next_hit;
         BG_MODE   <= CORE_HALTED;
         WDOG_HOLD <= CORE_HALTED;
         OSC_KEEP  <= ctrl[CTRL_EN_POS];
      end

   // ==========================================
   // checks
   a_halt_refused: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
      last_rx && refused |=> !GO && !STEP && !REG_WR && st == ST_CMD)
      else $error("halt-only command acted outside debug halt mode");

   a_zero_drive: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
      st == ST_RD && tx_bit && bit_on && cyc == 4'hc && tx_zero
      |=> DEBUG_PIN_OE && !DEBUG_PIN_OUT ##1 DEBUG_PIN_OE && DEBUG_PIN_OUT ##1 !DEBUG_PIN_OE)
      else $error("zero bit low phase or speedup wrong");

   a_one_speed: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
      st == ST_RD && tx_bit && bit_on && cyc == 4'h6 && !tx_zero
      |=> !DEBUG_PIN_OE ##1 DEBUG_PIN_OE && DEBUG_PIN_OUT ##1 !DEBUG_PIN_OE)
      else $error("one bit speedup misplaced");

   a_sample_time: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
      fall && st == ST_CMD |=> ##10 (sample || !rx_st || fall))
      else $error("bit not sampled ten cycles after start");

   a_timeout_abort: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
      timeout |=> st == ST_CMD && cnt == 5'h00 && !MEM_WR && !REG_WR && !FORCE_RST)
      else $error("timeout did not abort cleanly");

   a_halt_wake: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
      exec && cur_cmd == CMD_HALT |=> HALT_REQ)
      else $error("halt command did not request halt");

   a_boot_user: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
      boot_eval && !RST_CAUSE_POR && !RST_CAUSE_FORCED && !next_hit |=> !HALT_REQ)
      else $error("pin or error reset left user mode");

   a_boot_bg: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
      boot_eval && !pin_s2 && RST_CAUSE_POR |=> HALT_REQ)
      else $error("power-on with pin low did not enter halt");

   a_wdog_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
      WDOG_HOLD == BG_MODE)
      else $error("watchdog hold differs from debug halt mode");

   a_step_bg: assert property (@(posedge MCLK) disable iff (!RST_N || !CE)
      STEP || GO |-> $past(BG_MODE))
      else $error("step or resume issued outside debug halt mode");

   a_bkpt_halt: assert property (@(posedge MCLK) disable iff (!RST_N)
      BKPT_HIT |-> HALT_REQ)
      else $error("breakpoint hit without halt request");

   c_zero_bit: cover property (@(posedge MCLK) st == ST_RD && DEBUG_PIN_OE && !DEBUG_PIN_OUT);
   c_timeout: cover property (@(posedge MCLK) timeout);
   c_bkpt: cover property (@(posedge MCLK) BKPT_HIT);
   c_boot_bg: cover property (@(posedge MCLK) boot_bg);
endmodule
`default_nettype wire

// ---- bench/swbd_pod.sv ----
// debug pod model: host end of the single-wire debug link
`timescale 1ns/100ps
`default_nettype none
module swbd_pod
(
   input  wire logic        MCLK,
   input  wire logic        PIN,
   output var  logic        DRIVE_LOW,
   output var  logic [23:0] RX_VAL,
   output var  logic        RX_DONE
);
   // ==========================================
   // pod state
   initial
   begin
      DRIVE_LOW = 1'b0;
      RX_VAL    = 24'h000000;
      RX_DONE   = 1'b0;
   end

   task automatic hold(input logic l);
      @(negedge MCLK);
      DRIVE_LOW <= l;
   endtask

   // ==========================================
   // host-to-target bits, msb first, 20 cycles apart
   task automatic send(input logic [23:0] v, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         @(negedge MCLK);
         DRIVE_LOW <= 1'b1;
         repeat (v[i] ? 4 : 14) @(negedge MCLK);
         DRIVE_LOW <= 1'b0;
         repeat (v[i] ? 15 : 5) @(negedge MCLK);
      end
   endtask

   // ==========================================
   // target-to-host bits
   // low is held 7 cycles so the target takes over the low without a gap;
   // a gap would look like a fresh falling edge and restart the bit
   task automatic recv(input int n);
      logic [23:0] r;
      r = 24'h000000;
      for (int i = 0; i < n; i++)
      begin
         @(negedge MCLK);
         DRIVE_LOW <= 1'b1;
         repeat (7) @(negedge MCLK);
         DRIVE_LOW <= 1'b0;
         repeat (3) @(negedge MCLK);
         r = {r[22:0], PIN};
         repeat (9) @(negedge MCLK);
      end
      RX_VAL  <= r;
      RX_DONE <= 1'b1;
      @(negedge MCLK);
      RX_DONE <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- bench/single_wire_background_debug_ctrl_tb.sv ----
// self-checking bench for the single-wire debug controller
`timescale 1ns/100ps
`default_nettype none
module single_wire_background_debug_ctrl_tb;
   import swbd_pkg::*;
   typedef struct { string name; logic [23:0] val; } swbd_note_t;
   localparam int TO = 32;
   logic              mclk, rst_n, por, forced, halted, fetch, mem_ack, probe, halt_q, ce;
   logic [15:0]       core_addr, reg_rdata, d, bk, a;
   logic [7:0]        mem_rdata, b;
   wire  logic        pin_in, pod_low, pin_out, pin_oe, halt_req, go, step, reg_wr, mem_rd, mem_wr;
   wire  logic        force_rst, wdog, osc, bkpt, bg, rx_done;
   wire  logic [2:0]  reg_sel;
   wire  logic [15:0] reg_wdata, mem_addr;
   wire  logic [7:0]  mem_wdata;
   wire  logic [23:0] rx_val;
   int                fails, checked, cyc, seed;
   swbd_note_t        q[$];

   // released pin floats high through the pull-up
   assign pin_in = (pin_oe === 1'b1) ? pin_out : !pod_low;

   swbd_ctrl #(.TIMEOUT(TO)) dut (.MCLK(mclk), .RST_N(rst_n), .CE(ce), .DEBUG_PIN_IN(pin_in),
      .RST_CAUSE_POR(por), .RST_CAUSE_FORCED(forced), .CORE_HALTED(halted), .CORE_FETCH(fetch),
      .CORE_ADDR(core_addr), .REG_RDATA(reg_rdata), .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack),
      .DEBUG_PIN_OUT(pin_out), .DEBUG_PIN_OE(pin_oe), .HALT_REQ(halt_req), .GO(go), .STEP(step),
      .REG_WR(reg_wr), .REG_SEL(reg_sel), .REG_WDATA(reg_wdata), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
      .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .FORCE_RST(force_rst), .WDOG_HOLD(wdog),
      .OSC_KEEP(osc), .BKPT_HIT(bkpt), .BG_MODE(bg));

   swbd_pod pod (.MCLK(mclk), .PIN(pin_in), .DRIVE_LOW(pod_low), .RX_VAL(rx_val), .RX_DONE(rx_done));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ==========================================
   // core and memory stub
   always @(negedge mclk)
   begin
      mem_ack <= mem_rd;
      if (!rst_n)
         halted <= 1'b0;
      else if (halt_req === 1'b1)
         halted <= 1'b1;
      else if (go === 1'b1)
         halted <= 1'b0;
   end

   // ==========================================
   // expected notes and the watching process
   task automatic want(input string n, input logic [23:0] v);
      q.push_back('{n, v});
   endtask

   task automatic note(input string n, input logic [23:0] v);
      swbd_note_t e;
      checked++;
      if (q.size() == 0)
      begin
         fails++;
         $display("BAD %s exp none seen %h", n, v);
      end
      else
      begin
         e = q.pop_front();
         if (e.name != n || e.val !== v)
         begin
            fails++;
            $display("BAD %s exp %s %h seen %h", n, e.name, e.val, v);
         end
      end
   endtask

   always @(negedge mclk)
   begin
      if (rst_n === 1'b1)
      begin
         if (bkpt === 1'b1) note("bkpt", 24'h000001);
         if (halt_req === 1'b1 && halt_q !== 1'b1) note("halt", 24'h000001);
         if (go === 1'b1) note("go", 24'h000001);
         if (step === 1'b1) note("step", 24'h000001);
         if (force_rst === 1'b1) note("force", 24'h000001);
         if (reg_wr === 1'b1) note("reg", {5'h00, reg_sel, reg_wdata});
         if (mem_wr === 1'b1) note("memwr", {mem_addr, mem_wdata});
         if (mem_rd === 1'b1) note("memrd", {mem_addr, 8'h00});
         if (rx_done === 1'b1) note("rx", rx_val);
         if (probe === 1'b1) note("lvl", {21'h000000, osc, wdog, bg});
      end
      halt_q <= halt_req;
   end

   // ==========================================
   // driver helpers
   // the pod holds the debug pin low through reset here when low is set
   task automatic do_reset(input logic p, input logic f, input logic low, input logic hit);
      @(negedge mclk);
      rst_n = 1'b0;
      por = p;
      forced = f;
      pod.hold(low);
      if (hit) want("halt", 24'h000001);
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      repeat (6) @(negedge mclk);
      pod.hold(1'b0);
      repeat (30) @(negedge mclk);
   endtask

   task automatic cmd(input logic [7:0] c, input logic [23:0] arg, input int na, input int nr);
      pod.send({16'h0000, c}, 8);
      if (na > 0) pod.send(arg, na);
      repeat (4) @(negedge mclk);
      if (nr > 0) pod.recv(nr);
      repeat (8) @(negedge mclk);
   endtask

   task automatic level(input logic [2:0] e);
      want("lvl", {21'h000000, e});
      @(negedge mclk) probe <= 1'b1;
      @(negedge mclk) probe <= 1'b0;
   endtask

   task automatic end_sim;
      if (q.size() != 0)
      begin
         fails++;
         $display("BAD pending exp 0 seen %0d", q.size());
      end
      if (fails == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // hang guard, well above the roughly 10000 cycles the sequence needs
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         fails++;
         $display("BAD timeout exp 0 seen %0d", cyc);
         end_sim;
      end
   end

   // ==========================================
   // main sequence
   initial
   begin
      rst_n = 1'b0; por = 1'b1; forced = 1'b0; ce = 1'b1; fetch = 1'b0;
      probe = 1'b0; core_addr = 16'h0000; reg_rdata = 16'h0000; mem_rdata = 8'h00;
      fails = 0; checked = 0; cyc = 0; seed = 60930;
      do_reset(1'b1, 1'b0, 1'b1, 1'b1);
      do_reset(1'b1, 1'b0, 1'b0, 1'b0);
      do_reset(1'b0, 1'b0, 1'b1, 1'b0);
      do_reset(1'b0, 1'b1, 1'b1, 1'b1);
      level(3'b011);
      cmd(CMD_WR_CTRL, 24'h0000c0, 8, 0);
      level(3'b111);
      want("rx", 24'h0000e0);
      cmd(CMD_RD_STAT, 24'h000000, 0, 8);
      for (int i = 0; i < 8; i++)
      begin
         d = 16'($random(seed));
         want("reg", {5'h00, i[2:0], d});
         cmd({CMD_WREG_HI, i[2:0]}, {8'h00, d}, 16, 0);
      end
      reg_rdata = 16'($random(seed));
      want("rx", {8'h00, reg_rdata});
      cmd({CMD_RREG_HI, 3'h5}, 24'h000000, 0, 16);
      want("step", 24'h000001);
      cmd(CMD_STEP, 24'h000000, 0, 0);
      bk = 16'($random(seed));
      cmd(CMD_WR_BKPT, {8'h00, bk}, 16, 0);
      want("rx", {8'h00, bk});
      cmd(CMD_RD_BKPT, 24'h000000, 0, 16);
      want("go", 24'h000001);
      cmd(CMD_GO, 24'h000000, 0, 0);
      // a frozen controller must come back with its levels unchanged
      @(negedge mclk) ce = 1'b0;
      repeat (5) @(negedge mclk);
      ce = 1'b1;
      level(3'b100);
      cmd(CMD_STEP, 24'h000000, 0, 0);
      cmd(CMD_GO, 24'h000000, 0, 0);
      want("bkpt", 24'h000001);
      want("halt", 24'h000001);
      @(negedge mclk);
      fetch = 1'b1;
      core_addr = bk;
      @(negedge mclk);
      fetch = 1'b0;
      repeat (8) @(negedge mclk);
      want("go", 24'h000001);
      cmd(CMD_GO, 24'h000000, 0, 0);
      a = 16'($random(seed));
      b = 8'($random(seed));
      want("memwr", {a, b});
      cmd(CMD_WR_BYTE, {a, b}, 24, 0);
      mem_rdata = 8'($random(seed));
      want("memrd", {a, 8'h00});
      want("rx", {16'h0000, mem_rdata});
      cmd(CMD_RD_BYTE, {8'h00, a}, 16, 8);
      want("halt", 24'h000001);
      cmd(CMD_HALT, 24'h000000, 0, 0);
      want("force", 24'h000001);
      cmd(CMD_WR_FORCE, 24'h000001, 8, 0);
      pod.send(24'h00000c, 4);
      repeat (2 * TO) @(negedge mclk);
      want("memwr", {~a, b});
      cmd(CMD_WR_BYTE, {~a, b}, 24, 0);
      end_sim;
   end
endmodule
`default_nettype wire
